// ==== pkg/servo_io_defs.svh ====
`ifndef SERVO_IO_DEFS_SVH
`define SERVO_IO_DEFS_SVH

// register byte offsets
`define OFS_PIN2_SEL 8'h00
`define OFS_PIN3_SEL 8'h04
`define OFS_PIN4_SEL 8'h08
`define OFS_FILTER_CFG 8'h0C
`define OFS_STOP_OPTS 8'h10
`define OFS_RSVD_A 8'h14
`define OFS_CLEAR_MODE 8'h18
`define OFS_RSVD_B 8'h1C
`define OFS_WARN_OPTS 8'h20
`define OFS_LIVE_STATUS 8'h24
`define OFS_IRQ_STATUS 8'h28
`define OFS_IRQ_CLEAR 8'h2C
`define OFS_IRQ_ENABLE 8'h30
`define OFS_REINIT 8'h34

// reset values
`define RST_PIN2_SEL 16'h0004
`define RST_PIN3_SEL 16'h0002
`define RST_PIN4_SEL 16'h0005
`define RST_FILTER_CFG 16'h0002
`define RST_STOP_OPTS 16'h0000
`define RST_CLEAR_MODE 16'h0000
`define RST_WARN_OPTS 16'h0000
`define RST_RSVD 16'h0000

// field positions (one hex digit each, except the 5-bit select field)
`define FLT_GEN_LSB 0
`define FLT_FAULT_BIT 4
`define FLT_DROOP_BIT 8
`define STOP_SLOW_BIT 0
`define STOP_BASE_KEEP_BIT 4
`define STOP_TOUGH_OVL_BIT 8
`define CLR_LEVEL_BIT 0
`define WARN_BOTH_BIT 0
`define SEL_LSB 0

// device codes driven inside this block
`define DEV_OFF 5'h00
`define DEV_TROUBLE 5'h08
`define DEV_WARNING 5'h09
`define DEV_TOUGH 5'h0A

// interrupt bit positions
`define IRQ_LIMIT 0
`define IRQ_FAULT_CLR 1
`define IRQ_DROOP_CLR 2
`define IRQ_WARNING 3

// timing
`define CLK_FREQ_MHZ 50
`define FILT1_TIME_US 1777
`define FILT2_TIME_US 3555
`define FILT3_TIME_US 5333
`define FILT_DED_TIME_US 50000

`endif

// ==== pkg/servo_io_pkg.sv ====
package servo_io_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [4:0] dev_code_t;
    typedef logic [3:0] irq_vec_t;
    typedef enum logic [1:0] {
        FILT_NONE,
        FILT_SHORT,
        FILT_MID,
        FILT_LONG
    } filt_code_e;
endpackage

// ==== hdl/chatter_filter.sv ====
`timescale 1ns/1ps
module chatter_filter #(
    parameter int CNT_W = 22
) (
    // clock and reset
    input logic clock,
    input logic rst_n,
    // control
    input logic bypass,
    input logic [CNT_W-1:0] limit,
    // data
    input logic in_level,
    output logic out_level
);
    logic [CNT_W-1:0] cnt_r;

    initial begin
        if (CNT_W < 2 || CNT_W > 31) begin
            $error("chatter_filter: CNT_W out of range");
        end
    end

    // counter restarts whenever the raw level returns to the output level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r <= '0;
            out_level <= 1'b0;
        end else if (bypass) begin
            cnt_r <= '0;
            out_level <= in_level;
        end else if (in_level == out_level) begin
            cnt_r <= '0;
        end else if (cnt_r + 1'b1 >= limit) begin
            cnt_r <= '0;
            out_level <= in_level;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule

// ==== hdl/pin_select.sv ====
`timescale 1ns/1ps
module pin_select #(
    parameter int NDEV = 32
) (
    // clock and reset
    input logic clock,
    input logic rst_n,
    // selection
    input servo_io_pkg::dev_code_t sel,
    input logic [NDEV-1:0] devices,
    // pin
    output logic pin_out
);
    import servo_io_pkg::*;

    initial begin
        if (NDEV != 32) begin
            $error("pin_select: NDEV must match the 5-bit code");
        end
    end

    // same code table for every pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= devices[sel];
        end
    end
endmodule

// ==== hdl/servo_io_config.sv ====
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "servo_io_defs.svh"

module servo_io_config #(
    parameter int CNT_W = 22,
    parameter int FILT1_CYC = `FILT1_TIME_US * `CLK_FREQ_MHZ,
    parameter int FILT2_CYC = `FILT2_TIME_US * `CLK_FREQ_MHZ,
    parameter int FILT3_CYC = `FILT3_TIME_US * `CLK_FREQ_MHZ,
    parameter int FILT_DED_CYC = `FILT_DED_TIME_US * `CLK_FREQ_MHZ
) (
    // clock and reset
    input logic clock,
    input logic rst_n,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // raw input pins
    input logic fwd_limit_input,
    input logic rev_limit_input,
    input logic fault_clear_request,
    input logic droop_clear_input,
    // servo core status
    input logic [31:0] core_devices,
    input logic position_mode,
    input logic warning_active,
    input logic alarm_active,
    input logic power_fail_tough,
    input logic overload_tough,
    // programmable output pins and fixed status outputs
    output logic out_pin2,
    output logic out_pin3,
    output logic out_pin4,
    output logic warning_output,
    output logic trouble_output,
    output logic tough_drive_flag,
    // servo core commands
    output logic stop_request,
    output logic stop_slow,
    output logic droop_clear,
    output logic base_off,
    // interrupt
    output logic irq
);
    import servo_io_pkg::*;

    initial begin
        if (FILT1_CYC < 1 || FILT2_CYC < 1 || FILT3_CYC < 1 ||
            FILT_DED_CYC < 1 || FILT_DED_CYC >= (1 << CNT_W) ||
            FILT3_CYC >= (1 << CNT_W)) begin
            $error("servo_io_config: filter counts do not fit CNT_W");
        end
    end

    // software-visible copies and the copies in force
    reg_word_t pin2_pend_r, pin3_pend_r, pin4_pend_r;
    reg_word_t filt_pend_r, stop_pend_r, clr_pend_r, warn_pend_r;
    reg_word_t pin2_act_r, pin3_act_r, pin4_act_r;
    reg_word_t filt_act_r, stop_act_r, clr_act_r, warn_act_r;
    irq_vec_t irq_stat_r, irq_en_r, irq_evt, irq_clr;
    logic reinit;

    logic wr_en, rd_setup;
    logic [31:0] rd_data;
    logic rd_hit, wr_hit;

    logic [3:0] sync1_r, sync2_r, gen_out;
    logic [3:0] raw_pins;
    logic fault_filt, droop_filt;
    logic fault_prev_r, droop_prev_r, limit_stop_prev_r, warn_prev_r;
    logic [CNT_W-1:0] gen_limit;
    logic gen_bypass;
    logic limit_stop, droop_rise;
    logic tough_now, warn_level, trouble_level;
    logic [31:0] dev_vec;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;

    // apb write decode
    always_comb begin
        wr_hit = 1'b1;
        case (paddr)
            `OFS_PIN2_SEL, `OFS_PIN3_SEL, `OFS_PIN4_SEL,
            `OFS_FILTER_CFG, `OFS_STOP_OPTS, `OFS_CLEAR_MODE,
            `OFS_WARN_OPTS, `OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE,
            `OFS_REINIT: wr_hit = 1'b1;
            // writes to reserved words are dropped silently
            `OFS_RSVD_A, `OFS_RSVD_B: wr_hit = 1'b1;
            `OFS_LIVE_STATUS, `OFS_IRQ_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin2_pend_r <= `RST_PIN2_SEL;
            pin3_pend_r <= `RST_PIN3_SEL;
            pin4_pend_r <= `RST_PIN4_SEL;
            filt_pend_r <= `RST_FILTER_CFG;
            stop_pend_r <= `RST_STOP_OPTS;
            clr_pend_r <= `RST_CLEAR_MODE;
            warn_pend_r <= `RST_WARN_OPTS;
        end else if (wr_en) begin
            case (paddr)
                `OFS_PIN2_SEL: pin2_pend_r <= pwdata[15:0];
                `OFS_PIN3_SEL: pin3_pend_r <= pwdata[15:0];
                `OFS_PIN4_SEL: pin4_pend_r <= pwdata[15:0];
                `OFS_FILTER_CFG: filt_pend_r <= pwdata[15:0];
                `OFS_STOP_OPTS: stop_pend_r <= pwdata[15:0];
                `OFS_CLEAR_MODE: clr_pend_r <= pwdata[15:0];
                `OFS_WARN_OPTS: warn_pend_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    assign reinit = wr_en && (paddr == `OFS_REINIT) && pwdata[0];

    // settings in force only change at reset or reinit
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin2_act_r <= `RST_PIN2_SEL;
            pin3_act_r <= `RST_PIN3_SEL;
            pin4_act_r <= `RST_PIN4_SEL;
            filt_act_r <= `RST_FILTER_CFG;
            stop_act_r <= `RST_STOP_OPTS;
            clr_act_r <= `RST_CLEAR_MODE;
            warn_act_r <= `RST_WARN_OPTS;
        end else if (reinit) begin
            pin2_act_r <= pin2_pend_r;
            pin3_act_r <= pin3_pend_r;
            pin4_act_r <= pin4_pend_r;
            filt_act_r <= filt_pend_r;
            stop_act_r <= stop_pend_r;
            clr_act_r <= clr_pend_r;
            warn_act_r <= warn_pend_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_en_r <= '0;
        end else if (wr_en && paddr == `OFS_IRQ_ENABLE) begin
            irq_en_r <= pwdata[3:0];
        end
    end

    assign irq_clr = (wr_en && paddr == `OFS_IRQ_CLEAR) ?
        pwdata[3:0] : 4'h0;

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    // apb read mux, captured in the setup cycle
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `OFS_PIN2_SEL: rd_data[15:0] = pin2_pend_r;
            `OFS_PIN3_SEL: rd_data[15:0] = pin3_pend_r;
            `OFS_PIN4_SEL: rd_data[15:0] = pin4_pend_r;
            `OFS_FILTER_CFG: rd_data[15:0] = filt_pend_r;
            `OFS_STOP_OPTS: rd_data[15:0] = stop_pend_r;
            `OFS_CLEAR_MODE: rd_data[15:0] = clr_pend_r;
            `OFS_WARN_OPTS: rd_data[15:0] = warn_pend_r;
            `OFS_RSVD_A, `OFS_RSVD_B: rd_data[15:0] = `RST_RSVD;
            `OFS_LIVE_STATUS: rd_data[15:0] = {4'h0,
                stop_request, stop_slow, droop_clear, base_off,
                tough_drive_flag, trouble_output, warning_output,
                out_pin4, out_pin3, out_pin2, droop_filt, fault_filt};
            `OFS_IRQ_STATUS: rd_data[3:0] = irq_stat_r;
            `OFS_IRQ_ENABLE: rd_data[3:0] = irq_en_r;
            `OFS_IRQ_CLEAR, `OFS_REINIT: rd_data = 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= pwrite ? !wr_hit : !rd_hit;
        end
    end

    // pin synchronisers
    assign raw_pins = {droop_clear_input, fault_clear_request,
        rev_limit_input, fwd_limit_input};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= raw_pins;
            sync2_r <= sync1_r;
        end
    end

    // general filter window
    always_comb begin
        gen_bypass = 1'b0;
        gen_limit = CNT_W'(FILT2_CYC);
        case (filt_code_e'(filt_act_r[`FLT_GEN_LSB +: 2]))
            FILT_NONE: gen_bypass = 1'b1;
            FILT_SHORT: gen_limit = CNT_W'(FILT1_CYC);
            FILT_MID: gen_limit = CNT_W'(FILT2_CYC);
            FILT_LONG: gen_limit = CNT_W'(FILT3_CYC);
            default: gen_bypass = 1'b1;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_gen_filt
            chatter_filter #(
                .CNT_W(CNT_W)
            ) u_filt (
                .clock(clock),
                .rst_n(rst_n),
                .bypass(gen_bypass),
                .limit(gen_limit),
                .in_level(sync2_r[gi]),
                .out_level(gen_out[gi])
            );
        end
    endgenerate

    chatter_filter #(
        .CNT_W(CNT_W)
    ) u_fault_ded (
        .clock(clock),
        .rst_n(rst_n),
        .bypass(!filt_act_r[`FLT_FAULT_BIT]),
        .limit(CNT_W'(FILT_DED_CYC)),
        .in_level(gen_out[2]),
        .out_level(fault_filt)
    );

    chatter_filter #(
        .CNT_W(CNT_W)
    ) u_droop_ded (
        .clock(clock),
        .rst_n(rst_n),
        .bypass(!filt_act_r[`FLT_DROOP_BIT]),
        .limit(CNT_W'(FILT_DED_CYC)),
        .in_level(gen_out[3]),
        .out_level(droop_filt)
    );

    // limit inputs are on while motion is allowed
    assign limit_stop = !gen_out[0] || !gen_out[1];
    assign droop_rise = droop_filt && !droop_prev_r;
    assign tough_now = power_fail_tough ||
        (stop_act_r[`STOP_TOUGH_OVL_BIT] && overload_tough);

    // warning drives the warning pin, and the pair with WARN_BOTH_BIT set; otherwise the trouble pin follows alarm
    always_comb begin
        warn_level = 1'b0;
        trouble_level = alarm_active;
        if (warning_active) begin
            warn_level = 1'b1;
            trouble_level = alarm_active ||
                warn_act_r[`WARN_BOTH_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_prev_r <= 1'b0;
            droop_prev_r <= 1'b0;
            limit_stop_prev_r <= 1'b0;
            warn_prev_r <= 1'b0;
        end else begin
            fault_prev_r <= fault_filt;
            droop_prev_r <= droop_filt;
            limit_stop_prev_r <= limit_stop;
            warn_prev_r <= warning_active;
        end
    end

    assign irq_evt[`IRQ_LIMIT] = limit_stop && !limit_stop_prev_r;
    assign irq_evt[`IRQ_FAULT_CLR] = fault_filt && !fault_prev_r;
    assign irq_evt[`IRQ_DROOP_CLR] = droop_rise;
    assign irq_evt[`IRQ_WARNING] = warning_active && !warn_prev_r;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stop_request <= 1'b0;
            stop_slow <= 1'b0;
            droop_clear <= 1'b0;
            base_off <= 1'b0;
            tough_drive_flag <= 1'b0;
            warning_output <= 1'b0;
            trouble_output <= 1'b0;
        end else begin
            stop_request <= limit_stop;
            stop_slow <= limit_stop && stop_act_r[`STOP_SLOW_BIT];
            droop_clear <= (clr_act_r[`CLR_LEVEL_BIT] ?
                droop_filt : droop_rise) ||
                (limit_stop && position_mode &&
                !stop_act_r[`STOP_SLOW_BIT]);
            base_off <= fault_filt &&
                !stop_act_r[`STOP_BASE_KEEP_BIT];
            tough_drive_flag <= tough_now;
            warning_output <= warn_level;
            trouble_output <= trouble_level;
        end
    end

    // device table: core bits with in-block devices overlaid
    always_comb begin
        dev_vec = core_devices;
        dev_vec[`DEV_OFF] = 1'b0;
        dev_vec[`DEV_TROUBLE] = trouble_output;
        dev_vec[`DEV_WARNING] = warning_output;
        dev_vec[`DEV_TOUGH] = tough_drive_flag;
    end

    pin_select #(
        .NDEV(32)
    ) u_pin2 (
        .clock(clock),
        .rst_n(rst_n),
        .sel(pin2_act_r[`SEL_LSB +: 5]),
        .devices(dev_vec),
        .pin_out(out_pin2)
    );

    pin_select #(
        .NDEV(32)
    ) u_pin3 (
        .clock(clock),
        .rst_n(rst_n),
        .sel(pin3_act_r[`SEL_LSB +: 5]),
        .devices(dev_vec),
        .pin_out(out_pin3)
    );

    pin_select #(
        .NDEV(32)
    ) u_pin4 (
        .clock(clock),
        .rst_n(rst_n),
        .sel(pin4_act_r[`SEL_LSB +: 5]),
        .devices(dev_vec),
        .pin_out(out_pin4)
    );
endmodule

// ==== bench/servo_io_config_sva.sv ====
`timescale 1ns/1ps
module servo_io_checker (
    // clock and reset
    input logic clock,
    input logic rst_n,
    // pins and core levels
    input logic fwd_limit_input,
    input logic rev_limit_input,
    input logic fault_clear_request,
    input logic position_mode,
    input logic warning_active,
    input logic alarm_active,
    input logic power_fail_tough,
    input logic overload_tough,
    // outputs
    input logic warning_output,
    input logic trouble_output,
    input logic tough_drive_flag,
    input logic stop_request,
    input logic stop_slow,
    input logic droop_clear,
    input logic base_off,
    input logic irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // inputs pass 2 sync stages first, so look 3 back
    AST_STOP_CAUSE: assert property ($fell(stop_request) |->
        $past(fwd_limit_input, 3) && $past(rev_limit_input, 3))
        else $error("stop released with a limit off");
    AST_BASE_CAUSE: assert property ($rose(base_off) |->
        $past(fault_clear_request, 3))
        else $error("base off without fault clear");
    AST_WARN_OUT: assert property ($past(rst_n) |->
        warning_output == $past(warning_active))
        else $error("warning output does not follow warning");
    AST_TROUBLE_CAUSE: assert property ($past(rst_n) &&
        trouble_output && !$past(alarm_active) |-> $past(warning_active))
        else $error("trouble output without alarm or warning");
    AST_TOUGH_PF: assert property ($past(rst_n) &&
        $past(power_fail_tough) |-> tough_drive_flag)
        else $error("tough flag missing on power fail");
    AST_TOUGH_SRC: assert property (tough_drive_flag |->
        $past(power_fail_tough || overload_tough))
        else $error("tough flag without tough drive");
    AST_SLOW_NEEDS_STOP: assert property (stop_slow |->
        stop_request || $past(stop_request))
        else $error("slow stop without stop");
    AST_SUDDEN_CLEARS: assert property (stop_request [*3] ##0
        (!stop_slow && $past(position_mode)) |-> droop_clear)
        else $error("sudden stop did not clear droop");
    cover property (irq);
    cover property ($rose(base_off));
    cover property (stop_slow);
    cover property ($rose(droop_clear) ##1 !droop_clear);
endmodule

bind servo_io_config servo_io_checker i_servo_io_checker (.clock, .rst_n,
    .fwd_limit_input, .rev_limit_input, .fault_clear_request,
    .position_mode, .warning_active, .alarm_active, .power_fail_tough,
    .overload_tough, .warning_output, .trouble_output, .tough_drive_flag,
    .stop_request, .stop_slow, .droop_clear, .base_off, .irq);

// ==== bench/pin_host.sv ====
`timescale 1ns/1ps
module pin_host (
    // clock
    input logic clock,
    // discrete lines toward the block
    output logic fwd_limit_input,
    output logic rev_limit_input,
    output logic fault_clear_request,
    output logic droop_clear_input
);
    // limits on at start so motion is allowed
    logic [3:0] pins_r = 4'b1100;
    assign {fwd_limit_input, rev_limit_input} = pins_r[3:2];
    assign {fault_clear_request, droop_clear_input} = pins_r[1:0];
    task put(input int idx, input logic v);
        @(posedge clock);
        pins_r[idx] <= v;
    endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "servo_io_defs.svh"
module tb_top;
    import servo_io_pkg::*;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic e;
        logic [1:0] q;
    } note_s;
    note_s notes[$];
    note_s n;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [1:0] iq = 2'b00;
    dev_code_t c[3];
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic fwd_limit_input, rev_limit_input;
    logic fault_clear_request, droop_clear_input;
    logic [31:0] core_devices = 32'h0;
    logic position_mode = 1'b1;
    logic warning_active = 1'b0;
    logic alarm_active = 1'b0;
    logic power_fail_tough = 1'b0;
    logic overload_tough = 1'b0;
    logic out_pin2, out_pin3, out_pin4, warning_output, trouble_output;
    logic tough_drive_flag, stop_request, stop_slow, droop_clear;
    logic base_off, irq;

    always #10 clock = ~clock;

    // short filter counts keep the run brief
    servo_io_config #(.FILT1_CYC(5), .FILT2_CYC(10), .FILT3_CYC(15),
        .FILT_DED_CYC(40)) i_servo_io_config (.clock, .rst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fwd_limit_input, .rev_limit_input, .fault_clear_request,
        .droop_clear_input, .core_devices, .position_mode, .warning_active,
        .alarm_active, .power_fail_tough, .overload_tough, .out_pin2,
        .out_pin3, .out_pin4, .warning_output, .trouble_output,
        .tough_drive_flag, .stop_request, .stop_slow, .droop_clear,
        .base_off, .irq);
    pin_host i_pin_host (.clock, .fwd_limit_input, .rev_limit_input,
        .fault_clear_request, .droop_clear_input);

    task wrap_up;
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task cyc_w(input int k);
        repeat (k) @(posedge clock);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        note_s t;
        t.d = d;
        t.m = m;
        t.e = (a > `OFS_REINIT);
        t.q = iq;
        notes.push_back(t);
        apb(1'b0, a, 32'h0);
    endtask

    task st(input int b, input logic v);
        rd(`OFS_LIVE_STATUS, 32'(v) << b, 32'h1 << b);
    endtask

    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite) begin
            n = notes.pop_front();
            n_compared++;
            if ({prdata & n.m, pslverr} !== {n.d & n.m, n.e}) begin
                failures++;
                $display("CHECK FAILED read %h exp %h seen %h", paddr,
                    {n.d & n.m, n.e}, {prdata & n.m, pslverr});
            end
            if (n.q[1] && irq !== n.q[0]) begin
                failures++;
                $display("CHECK FAILED irq exp %b seen %b", n.q[0], irq);
            end
        end
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h1850));
        @(posedge clock);
        core_devices <= $urandom();
        repeat (11) @(posedge clock);
        rst_n <= 1'b1;
        cyc_w(30);
        rd(`OFS_PIN2_SEL, 32'h4, '1);
        rd(`OFS_PIN3_SEL, 32'h2, '1);
        rd(`OFS_PIN4_SEL, 32'h5, '1);
        rd(`OFS_FILTER_CFG, 32'h2, '1);
        rd(`OFS_STOP_OPTS, 32'h0, '1);
        rd(`OFS_RSVD_A, 32'h0, '1);
        rd(`OFS_CLEAR_MODE, 32'h0, '1);
        rd(`OFS_RSVD_B, 32'h0, '1);
        rd(`OFS_WARN_OPTS, 32'h0, '1);
        rd(8'h3C, 32'h0, '1);
        st(2, core_devices[4]);
        st(3, core_devices[2]);
        st(4, core_devices[5]);
        for (int i = 0; i < 3; i++) begin
            c[i] = 5'($urandom());
            // codes driven inside the block are kept out
            if (c[i] inside {5'h00, 5'h08, 5'h09, 5'h0A})
                c[i] = 5'h1F;
            wr(`OFS_PIN2_SEL + 8'(4 * i), 32'(c[i]));
        end
        st(2, core_devices[4]);
        wr(`OFS_REINIT, 32'h1);
        for (int r = 0; r < 2; r++) begin
            cyc_w(3);
            for (int i = 0; i < 3; i++)
                st(2 + i, core_devices[c[i]]);
            core_devices <= $urandom();
        end
        for (int f = 0; f < 4; f++) begin
            int nc;
            nc = (f == 0) ? 1 : 5 * f;
            wr(`OFS_FILTER_CFG, 32'(f));
            wr(`OFS_REINIT, 32'h1);
            i_pin_host.put(1, 1'b1);
            if (f != 0) begin
                cyc_w(nc - 3);
                st(0, 1'b0);
            end
            cyc_w(nc + 6);
            st(0, 1'b1);
            i_pin_host.put(1, 1'b0);
            cyc_w(nc + 6);
        end
        i_pin_host.put(1, 1'b1);
        cyc_w(8);
        i_pin_host.put(1, 1'b0);
        cyc_w(20);
        st(0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            wr(`OFS_FILTER_CFG, 32'h10 << (4 * k));
            wr(`OFS_REINIT, 32'h1);
            i_pin_host.put(1 - k, 1'b1);
            cyc_w(25);
            st(k, 1'b0);
            cyc_w(30);
            st(k, 1'b1);
            i_pin_host.put(1 - k, 1'b0);
            cyc_w(50);
        end
        i_pin_host.put(1, 1'b1);
        cyc_w(6);
        st(8, 1'b1);
        wr(`OFS_STOP_OPTS, 32'h10);
        wr(`OFS_REINIT, 32'h1);
        cyc_w(3);
        st(8, 1'b0);
        i_pin_host.put(1, 1'b0);
        wr(`OFS_FILTER_CFG, 32'h0);
        // third pass: sudden stop outside position control keeps droop
        for (int s = 0; s < 3; s++) begin
            wr(`OFS_STOP_OPTS, 32'(s & 1));
            wr(`OFS_REINIT, 32'h1);
            position_mode <= (s != 2);
            i_pin_host.put(3 - (s & 1), 1'b0);
            cyc_w(6);
            rd(`OFS_LIVE_STATUS, {20'h0, 1'b1, s[0], (s == 0), 9'h0},
                32'hE00);
            i_pin_host.put(3 - (s & 1), 1'b1);
            cyc_w(6);
            st(11, 1'b0);
        end
        position_mode <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(`OFS_CLEAR_MODE, 32'(m));
            wr(`OFS_REINIT, 32'h1);
            i_pin_host.put(0, 1'b1);
            cyc_w(8);
            st(9, m[0]);
            i_pin_host.put(0, 1'b0);
            cyc_w(8);
            st(9, 1'b0);
        end
        wr(`OFS_IRQ_CLEAR, 32'hF);
        wr(`OFS_IRQ_ENABLE, 32'h8);
        for (int w = 0; w < 2; w++) begin
            wr(`OFS_WARN_OPTS, 32'(w));
            wr(`OFS_REINIT, 32'h1);
            warning_active <= 1'b1;
            cyc_w(3);
            rd(`OFS_LIVE_STATUS, {25'h0, w[0], 1'b1, 5'h0}, 32'h60);
            warning_active <= 1'b0;
            cyc_w(3);
        end
        alarm_active <= 1'b1;
        cyc_w(3);
        st(6, 1'b1);
        alarm_active <= 1'b0;
        iq = 2'b11;
        rd(`OFS_IRQ_STATUS, 32'h8, 32'h8);
        wr(`OFS_IRQ_ENABLE, 32'h0);
        iq = 2'b10;
        rd(`OFS_IRQ_ENABLE, 32'h0, '1);
        wr(`OFS_IRQ_ENABLE, 32'h8);
        wr(`OFS_IRQ_CLEAR, 32'h8);
        rd(`OFS_IRQ_STATUS, 32'h0, 32'h8);
        iq = 2'b00;
        for (int t = 0; t < 2; t++) begin
            wr(`OFS_STOP_OPTS, 32'(t) << 8);
            wr(`OFS_REINIT, 32'h1);
            overload_tough <= 1'b1;
            cyc_w(3);
            st(7, t[0]);
            overload_tough <= 1'b0;
            power_fail_tough <= 1'b1;
            cyc_w(3);
            st(7, 1'b1);
            power_fail_tough <= 1'b0;
        end
        cyc_w(5);
        wrap_up();
    end
endmodule
